/* File: logic/tfc_function_ctrl.sv */
// Function control byte, position entry and common error output block
//
// Added by the designer: the address map and the APB slave port.
module tfc_function_ctrl
	import tfc_pkg::*;
#(
	parameter int unsigned MS_CYC = TFC_MS_CYC,
	parameter int unsigned SIM_MS = TFC_SIM_MS
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Pins from the time system
	input  wire logic        second_pulse_in,
	input  wire logic        source_sync_in,
	input  wire logic [15:0] err_in,
	// Pins to the outside
	output logic             front_connector_out,
	output logic             common_error_out,
	output logic             error_indicator,
	output logic             sync_status_out,
	output logic             sim_mode_active,
	output logic             source_auto_switch,
	output logic             string_time_is_utc,
	output logic             use_internal_offset
);

	// ==========================================================
	// Helpers
	function automatic logic pos_ok(input logic [16:0] w, input logic [7:0] dmax);
		pos_ok = (w[TFC_POS_DEG_LSB +: 8] <= dmax) && (w[TFC_POS_MIN_LSB +: 6] <= TFC_MIN_MAX)
			&& (w[7:6] == 2'b00);
	endfunction : pos_ok

	function automatic logic any_level(input logic [15:0] e, input logic [31:0] p,
		input logic [1:0] lvl);
		any_level = 1'b0;
		for (int i = 0; i < 16; i++)
			if (e[i] && (p[2*i +: 2] == lvl))
				any_level = 1'b1;
	endfunction : any_level

	// ==========================================================
	// Pin synchronisers
	logic [17:0] sync1_reg;
	logic [17:0] sync2_reg;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_reg <= 18'h00000;
			sync2_reg <= 18'h00000;
		end else begin
			sync1_reg <= {second_pulse_in, source_sync_in, err_in};
			sync2_reg <= sync1_reg;
		end
	end
	logic        pps_s;
	logic        src_sync_s;
	logic [15:0] err_s;
	assign pps_s      = sync2_reg[17];
	assign src_sync_s = sync2_reg[16];
	assign err_s      = sync2_reg[15:0];

	// ==========================================================
	// Millisecond timebase
	logic       ms_tick;
	logic [9:0] ms_phase;
	tfc_ms_timer #(
		.MS_CYC   (MS_CYC)
	) u_timer (
		.clock    (clock),
		.rst_n    (rst_n),
		.ms_tick  (ms_tick),
		.ms_phase (ms_phase)
	);

	// ==========================================================
	// APB decode
	logic wr_en;
	logic rd_en;
	logic hit;
	logic bad_pos;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign hit   = (paddr == TFC_OFF_FUNC_CTRL) || (paddr == TFC_OFF_OP_MODE)
		|| (paddr == TFC_OFF_STATUS) || (paddr == TFC_OFF_LATITUDE)
		|| (paddr == TFC_OFF_LONGITUDE) || (paddr == TFC_OFF_ERR_PRIO);
	// Out of range position is refused, old value kept
	assign bad_pos = pwrite && (((paddr == TFC_OFF_LATITUDE)
		&& !pos_ok(pwdata[16:0], TFC_LAT_DEG_MAX)) || ((paddr == TFC_OFF_LONGITUDE)
		&& !pos_ok(pwdata[16:0], TFC_LON_DEG_MAX)));
	assign pready  = 1'b1;
	assign pslverr = psel && penable && (!hit || bad_pos);

	// ==========================================================
	// Register file and simulation state
	logic [7:0]  func_reg,  func_next;
	tfc_mode_e   mode_reg,  mode_next;
	logic [16:0] lat_reg,   lat_next;
	logic [16:0] lon_reg,   lon_next;
	logic [31:0] prio_reg,  prio_next;
	tfc_sim_e    sim_reg,   sim_next;
	logic [23:0] simcnt_reg, simcnt_next;

	always_comb begin
		func_next   = func_reg;
		mode_next   = mode_reg;
		lat_next    = lat_reg;
		lon_next    = lon_reg;
		prio_next   = prio_reg;
		sim_next    = sim_reg;
		simcnt_next = simcnt_reg;
		// Four hour count runs on the ms enable
		if ((sim_reg == TFC_SIM_TIMED) && ms_tick)
			simcnt_next = simcnt_reg + 24'h000001;
		if ((sim_reg == TFC_SIM_TIMED) && ms_tick && (simcnt_reg == 24'(SIM_MS - 1))) begin
			if (mode_reg == TFC_MODE_QUARTZ) begin
				sim_next = TFC_SIM_HELD;
			end else begin
				sim_next = TFC_SIM_OFF;
				func_next[TFC_FC_SIM_BIT] = 1'b0;
			end
		end
		if (wr_en && hit && !bad_pos) begin
			case (paddr)
				TFC_OFF_FUNC_CTRL: begin
					if (pstrb[0])
						func_next = pwdata[7:0];
					if (pstrb[0] && pwdata[TFC_FC_SIM_BIT] && !func_reg[TFC_FC_SIM_BIT]) begin
						sim_next    = TFC_SIM_TIMED;
						simcnt_next = 24'h000000;
					end else if (pstrb[0] && !pwdata[TFC_FC_SIM_BIT]) begin
						sim_next = TFC_SIM_OFF;
					end
				end
				TFC_OFF_OP_MODE: begin
					if (pstrb[0] && (pwdata[1:0] != 2'b11))
						mode_next = tfc_mode_e'(pwdata[1:0]);
				end
				TFC_OFF_LATITUDE: begin
					if (pstrb == 4'hf)
						lat_next = pwdata[16:0];
				end
				TFC_OFF_LONGITUDE: begin
					if (pstrb == 4'hf)
						lon_next = pwdata[16:0];
				end
				TFC_OFF_ERR_PRIO: begin
					if (pstrb[1:0] == 2'b11)
						prio_next[15:0] = pwdata[15:0];
					if (pstrb[3:2] == 2'b11)
						prio_next[31:16] = pwdata[31:16];
				end
				default: begin
					func_next = func_next;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			func_reg   <= TFC_FUNC_RST;
			mode_reg   <= TFC_MODE_SATELLITE;
			lat_reg    <= TFC_POS_RST;
			lon_reg    <= TFC_POS_RST;
			prio_reg   <= TFC_PRIO_RST;
			sim_reg    <= TFC_SIM_OFF;
			simcnt_reg <= 24'h000000;
		end else begin
			func_reg   <= func_next;
			mode_reg   <= mode_next;
			lat_reg    <= lat_next;
			lon_reg    <= lon_next;
			prio_reg   <= prio_next;
			sim_reg    <= sim_next;
			simcnt_reg <= simcnt_next;
		end
	end

	// ==========================================================
	// Error grouping; error 0 is the sync loss error
	logic        sim_on;
	logic [15:0] err_eff;
	logic        err_major;
	logic        err_minor;
	logic        err_any;
	assign sim_on = (sim_reg != TFC_SIM_OFF);
	assign err_eff   = {err_s[15:1], err_s[0] && !sim_on};
	assign err_major = any_level(err_eff, prio_reg, TFC_PRIO_MAJOR);
	assign err_minor = any_level(err_eff, prio_reg, TFC_PRIO_MINOR);
	assign err_any   = err_major || err_minor;

	// ==========================================================
	// Output registers
	logic outs_next_err;
	logic [7:0] outs_reg, outs_next;
	always_comb begin
		// 980/20 no error, 20/980 minor, major low
		if (func_reg[TFC_FC_DYN_BIT])
			outs_next_err = !err_major && (err_minor ? (ms_phase < 10'(TFC_ERR_SHORT_MS))
				: (ms_phase < 10'(TFC_ERR_LONG_MS)));
		else
			outs_next_err = err_any;
		outs_next[0] = outs_next_err;
		outs_next[1] = func_reg[TFC_FC_OSEL_BIT] ? outs_next_err : pps_s;
		outs_next[2] = err_any;
		outs_next[3] = sim_on || src_sync_s;
		outs_next[4] = sim_on;
		outs_next[5] = !func_reg[TFC_FC_MANUAL_BIT];
		outs_next[6] = func_reg[TFC_FC_EVAL_BIT] && func_reg[TFC_FC_TBASE_BIT];
		outs_next[7] = func_reg[TFC_FC_EVAL_BIT];
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			outs_reg <= 8'h20;
		else
			outs_reg <= outs_next;
	end

	assign common_error_out    = outs_reg[0];
	assign front_connector_out = outs_reg[1];
	assign error_indicator     = outs_reg[2];
	assign sync_status_out     = outs_reg[3];
	assign sim_mode_active     = outs_reg[4];
	assign source_auto_switch  = outs_reg[5];
	assign string_time_is_utc  = outs_reg[6];
	assign use_internal_offset = outs_reg[7];

	// ==========================================================
	// Read mux; status shows live block state
	always_comb begin
		prdata = 32'h00000000;
		if (rd_en) begin
			case (paddr)
				TFC_OFF_FUNC_CTRL: prdata = {24'h000000, func_reg};
				TFC_OFF_OP_MODE:   prdata = {30'h00000000, mode_reg};
				TFC_OFF_STATUS:    prdata = {20'h00000, sim_reg, err_major, err_minor, outs_reg};
				TFC_OFF_LATITUDE:  prdata = {15'h0000, lat_reg};
				TFC_OFF_LONGITUDE: prdata = {15'h0000, lon_reg};
				TFC_OFF_ERR_PRIO:  prdata = prio_reg;
				default:           prdata = 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// Assertions
	property p_sel_front;
		@(posedge clock) disable iff (!rst_n)
		func_reg[TFC_FC_OSEL_BIT] && $stable(func_reg) |=> front_connector_out == outs_reg[0];
	endproperty
	a_sel_front: assert property (p_sel_front) else $error("front output not error");

	property p_auto;
		@(posedge clock) disable iff (!rst_n)
		##1 source_auto_switch == !$past(func_reg[TFC_FC_MANUAL_BIT]);
	endproperty
	a_auto: assert property (p_auto) else $error("changeover mode wrong");

	property p_tbase;
		@(posedge clock) disable iff (!rst_n)
		!func_reg[TFC_FC_EVAL_BIT] |=> !string_time_is_utc;
	endproperty
	a_tbase: assert property (p_tbase) else $error("time base used in standard eval");

	property p_sim_sync;
		@(posedge clock) disable iff (!rst_n)
		sim_on |=> sync_status_out && sim_mode_active;
	endproperty
	a_sim_sync: assert property (p_sim_sync) else $error("sim not synchronous");

	property p_timeout;
		@(posedge clock) disable iff (!rst_n)
		(sim_reg == TFC_SIM_TIMED) && ms_tick && (simcnt_reg == 24'(SIM_MS - 1))
			&& (mode_reg != TFC_MODE_QUARTZ) && !wr_en |=> !sim_on ##1 !sim_mode_active;
	endproperty
	a_timeout: assert property (p_timeout) else $error("sim did not end");

	property p_held;
		@(posedge clock) disable iff (!rst_n)
		(sim_reg == TFC_SIM_HELD) && !wr_en |=> sim_reg == TFC_SIM_HELD;
	endproperty
	a_held: assert property (p_held) else $error("quartz sim lost");

	property p_lat;
		@(posedge clock) disable iff (!rst_n)
		wr_en && (paddr == TFC_OFF_LATITUDE) && (pwdata[15:8] > TFC_LAT_DEG_MAX)
			|-> pslverr ##1 $stable(lat_reg);
	endproperty
	a_lat: assert property (p_lat) else $error("bad latitude taken");

	property p_static;
		@(posedge clock) disable iff (!rst_n)
		!func_reg[TFC_FC_DYN_BIT] |=> common_error_out == $past(err_any);
	endproperty
	a_static: assert property (p_static) else $error("static error level wrong");

	property p_major;
		@(posedge clock) disable iff (!rst_n)
		func_reg[TFC_FC_DYN_BIT] && err_major |=> !common_error_out;
	endproperty
	a_major: assert property (p_major) else $error("major error not low");

	property p_ind;
		@(posedge clock) disable iff (!rst_n)
		##1 error_indicator == $past(err_any);
	endproperty
	a_ind: assert property (p_ind) else $error("indicator wrong");

endmodule : tfc_function_ctrl

/* File: include/tfc_pkg.sv */
// Package: register map, field layout, reset values and timing for the function control block
package tfc_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] TFC_OFF_FUNC_CTRL = 8'h00;
	localparam logic [7:0] TFC_OFF_OP_MODE   = 8'h04;
	localparam logic [7:0] TFC_OFF_STATUS    = 8'h08;
	localparam logic [7:0] TFC_OFF_LATITUDE  = 8'h0c;
	localparam logic [7:0] TFC_OFF_LONGITUDE = 8'h10;
	localparam logic [7:0] TFC_OFF_ERR_PRIO  = 8'h14;

	// ==========================================================
	// Function control byte fields
	localparam int TFC_FC_SIM_BIT   = 0;
	localparam int TFC_FC_EVAL_BIT  = 1;
	localparam int TFC_FC_TBASE_BIT = 2;
	localparam int TFC_FC_MANUAL_BIT= 3;
	localparam int TFC_FC_OSEL_BIT  = 4;
	localparam int TFC_FC_DYN_BIT   = 5;

	// ==========================================================
	// Position word: sign, degrees, minutes
	localparam int TFC_POS_SIGN_BIT = 16;
	localparam int TFC_POS_DEG_LSB  = 8;
	localparam int TFC_POS_MIN_LSB  = 0;
	localparam logic [7:0] TFC_LAT_DEG_MAX = 8'h59;
	localparam logic [7:0] TFC_LON_DEG_MAX = 8'hb3;
	localparam logic [5:0] TFC_MIN_MAX     = 6'h3b;

	// ==========================================================
	// Reset values
	localparam logic [7:0]  TFC_FUNC_RST = 8'h00;
	localparam logic [16:0] TFC_POS_RST  = 17'h00000;
	localparam logic [31:0] TFC_PRIO_RST = 32'haaaaaaaa;

	// ==========================================================
	// Error priority codes and operating modes
	typedef enum logic [1:0] {
		TFC_PRIO_MASKED = 2'b00,
		TFC_PRIO_MINOR  = 2'b01,
		TFC_PRIO_MAJOR  = 2'b10
	} tfc_prio_e;

	typedef enum logic [1:0] {
		TFC_MODE_QUARTZ    = 2'b00,
		TFC_MODE_SATELLITE = 2'b01,
		TFC_MODE_STRING    = 2'b10
	} tfc_mode_e;

	typedef enum logic [1:0] {
		TFC_SIM_OFF   = 2'b00,
		TFC_SIM_TIMED = 2'b01,
		TFC_SIM_HELD  = 2'b10
	} tfc_sim_e;

	// ==========================================================
	// Timing
	localparam int TFC_CLK_NS       = 10;
	localparam int TFC_MS_NS        = 1000000;
	localparam int TFC_MS_CYC       = TFC_MS_NS / TFC_CLK_NS;
	localparam int TFC_SIM_HOURS    = 4;
	localparam int TFC_SIM_MS       = TFC_SIM_HOURS * 3600 * 1000;
	localparam int TFC_ERR_PERIOD_MS= 1000;
	localparam int TFC_ERR_LONG_MS  = 980;
	localparam int TFC_ERR_SHORT_MS = 20;

endpackage : tfc_pkg

/* File: logic/tfc_ms_timer.sv */
// Millisecond enable pulse and phase within the one-second error output frame
module tfc_ms_timer
	import tfc_pkg::*;
#(
	parameter int unsigned MS_CYC = TFC_MS_CYC
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Timebase outputs
	output logic            ms_tick,
	output logic [9:0]      ms_phase
);

	// ==========================================================
	// Divider
	logic [16:0] div_reg;
	logic [16:0] div_next;
	logic [9:0]  phase_reg;
	logic [9:0]  phase_next;
	logic        tick_reg;
	logic        tick_next;

	// Next state: one tick per millisecond, phase wraps each second
	always_comb begin
		div_next   = div_reg + 17'h00001;
		phase_next = phase_reg;
		tick_next  = 1'b0;
		if (div_reg == 17'(MS_CYC - 1)) begin
			div_next  = 17'h00000;
			tick_next = 1'b1;
			if (phase_reg == 10'(TFC_ERR_PERIOD_MS - 1))
				phase_next = 10'h000;
			else
				phase_next = phase_reg + 10'h001;
		end
	end

	// Registers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			div_reg   <= 17'h00000;
			phase_reg <= 10'h000;
			tick_reg  <= 1'b0;
		end else begin
			div_reg   <= div_next;
			phase_reg <= phase_next;
			tick_reg  <= tick_next;
		end
	end

	assign ms_tick  = tick_reg;
	assign ms_phase = phase_reg;

endmodule : tfc_ms_timer

/* File: tb/tfc_time_source.sv */
// Far-side model: second pulse, source sync level and error lines
module tfc_time_source #(
	parameter int PPS_CYC = 100
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Scenario control
	input  wire logic        sync_req,
	input  wire logic [15:0] err_req,
	// Lines into the block
	output logic             second_pulse_in,
	output logic             source_sync_in,
	output logic [15:0]      err_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Lines settle at the first edge, while the block is still in reset
	int cnt = 0;
	// One-cycle pulse per modelled second, shortened so scenarios stay brief
	always @(posedge clock) begin
		cnt <= (!rst_n || cnt == PPS_CYC - 1) ? 0 : cnt + 1;
		second_pulse_in <= rst_n && cnt == 0;
		source_sync_in <= sync_req;
		err_in <= err_req;
	end
endmodule : tfc_time_source

/* File: tb/tfc_function_ctrl_tb_top.sv */
// Testbench: control byte, position, error grouping, error output and simulation
module tfc_function_ctrl_tb_top import tfc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals
	logic        clock = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, er;
	logic [31:0] prdata, rd;
	logic        second_pulse_in, source_sync_in;
	logic        sync_req = 1'h0;
	logic [15:0] err_in;
	logic [15:0] err_req = 16'h0000;
	logic        front_connector_out, common_error_out, error_indicator, sync_status_out;
	logic        sim_mode_active, source_auto_switch, string_time_is_utc, use_internal_offset;
	int          err_total = 0;
	int          checks = 0;
	// Clock at 100 MHz
	always #5 clock = ~clock;
	// ==========================================================
	// Instances: counts shortened, 10 cycles per ms and 5 ms of simulation
	tfc_function_ctrl #(.MS_CYC(10), .SIM_MS(5)) u_tfc_function_ctrl (.clock, .rst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
		.second_pulse_in, .source_sync_in, .err_in, .front_connector_out,
		.common_error_out, .error_indicator, .sync_status_out, .sim_mode_active,
		.source_auto_switch, .string_time_is_utc, .use_internal_offset);
	tfc_time_source #(.PPS_CYC(100)) u_tfc_time_source (.clock, .rst_n, .sync_req,
		.err_req, .second_pulse_in, .source_sync_in, .err_in);
	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	// Setup then access; held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clock);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		// Strobes stay low on reads
		pstrb <= w ? s : 4'h0;
		@(posedge clock);
		penable <= 1'h1;
		// No timeout of its own; this wait ends when pready is seen high
		do
			@(posedge clock);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// High cycles of the common error over one full output second
	task automatic hi_count(input int exp);
		int h;
		h = 0;
		repeat (10000) begin
			@(posedge clock);
			h += (common_error_out === 1'h1);
		end
		chk(h, exp);
	endtask : hi_count
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		apb(1'h0, TFC_OFF_FUNC_CTRL, 32'h0, 4'hf);
		chk(rd, 32'h0);
		chk(source_auto_switch, 1'h1);
		apb(1'h0, TFC_OFF_ERR_PRIO, 32'h0, 4'hf);
		chk(rd, 32'haaaaaaaa);
		// Unmapped address: error flag and zero data checked apart
		apb(1'h0, 8'h40, 32'h0, 4'hf);
		chk(er, 1'h1);
		chk(rd, 32'h0);
		$display("reset values done");
	endtask : t_reset
	task automatic t_func;
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h0e, 4'hf);
		cyc(3);
		chk({string_time_is_utc, use_internal_offset}, 2'h3);
		chk(source_auto_switch, 1'h0);
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h04, 4'hf);
		cyc(3);
		chk({string_time_is_utc, use_internal_offset}, 2'h0);
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h02, 4'hf);
		cyc(3);
		chk({string_time_is_utc, use_internal_offset}, 2'h1);
		$display("control byte done");
	endtask : t_func
	task automatic t_pos;
		apb(1'h1, TFC_OFF_LATITUDE, 32'h0001593b, 4'hf);
		chk(er, 1'h0);
		apb(1'h1, TFC_OFF_LATITUDE, 32'h00005a00, 4'hf);
		chk(er, 1'h1);
		apb(1'h0, TFC_OFF_LATITUDE, 32'h0, 4'hf);
		chk(rd, 32'h0001593b);
		apb(1'h1, TFC_OFF_LONGITUDE, 32'h0000b33b, 4'hf);
		chk(er, 1'h0);
		apb(1'h1, TFC_OFF_LONGITUDE, 32'h0000b400, 4'hf);
		chk(er, 1'h1);
		apb(1'h1, TFC_OFF_LONGITUDE, 32'h0001003c, 4'hf);
		chk(er, 1'h1);
		apb(1'h0, TFC_OFF_LONGITUDE, 32'h0, 4'hf);
		chk(rd, 32'h0000b33b);
		$display("position done");
	endtask : t_pos
	task automatic t_prio;
		logic hi, lo;
		apb(1'h1, TFC_OFF_ERR_PRIO, 32'h0, 4'h3);
		apb(1'h0, TFC_OFF_ERR_PRIO, 32'h0, 4'hf);
		chk(rd, 32'haaaa0000);
		// Upper group only; lower group must stay as written before
		apb(1'h1, TFC_OFF_ERR_PRIO, 32'h5555ffff, 4'hc);
		apb(1'h0, TFC_OFF_ERR_PRIO, 32'h0, 4'hf);
		chk(rd, 32'h55550000);
		err_req <= 16'h0002;
		cyc(5);
		chk({error_indicator, common_error_out}, 2'h0);
		apb(1'h1, TFC_OFF_ERR_PRIO, 32'haaaaaaaa, 4'hf);
		cyc(5);
		chk(error_indicator, 1'h1);
		chk(common_error_out, 1'h1);
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h10, 4'hf);
		cyc(4);
		chk(front_connector_out, 1'h1);
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h00, 4'hf);
		@(posedge second_pulse_in);
		hi = 1'h0;
		lo = 1'h0;
		repeat (8) begin
			@(posedge clock);
			hi |= (front_connector_out === 1'h1);
			lo |= (front_connector_out === 1'h0);
		end
		chk({hi, lo}, 2'h3);
		$display("error grouping done");
	endtask : t_prio
	task automatic t_dyn;
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h20, 4'hf);
		cyc(5);
		hi_count(0);
		apb(1'h1, TFC_OFF_ERR_PRIO, 32'haaaaaaa6, 4'hf);
		cyc(5);
		hi_count(200);
		err_req <= 16'h0000;
		cyc(5);
		hi_count(9800);
		$display("dynamic output done");
	endtask : t_dyn
	task automatic t_sim;
		// Source sync level passes through when not simulating
		sync_req <= 1'h1;
		cyc(5);
		chk(sync_status_out, 1'h1);
		sync_req <= 1'h0;
		cyc(5);
		chk(sync_status_out, 1'h0);
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h01, 4'hf);
		cyc(3);
		chk({sync_status_out, sim_mode_active}, 2'h3);
		cyc(100);
		chk(sim_mode_active, 1'h0);
		apb(1'h0, TFC_OFF_FUNC_CTRL, 32'h0, 4'hf);
		chk(rd[0], 1'h0);
		apb(1'h1, TFC_OFF_OP_MODE, 32'h0, 4'hf);
		apb(1'h1, TFC_OFF_FUNC_CTRL, 32'h01, 4'hf);
		cyc(100);
		chk(sim_mode_active, 1'h1);
		apb(1'h0, TFC_OFF_STATUS, 32'h0, 4'hf);
		chk(rd[11:10], 2'h2);
		rst_n <= 1'h0;
		cyc(3);
		rst_n <= 1'h1;
		cyc(3);
		chk({sync_status_out, sim_mode_active}, 2'h0);
		$display("simulation done");
	endtask : t_sim
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		cyc(8);
		rst_n <= 1'h1;
		cyc(3);
		t_reset();
		t_func();
		t_pos();
		t_prio();
		t_dyn();
		t_sim();
		wrap_up();
	end
	initial begin
		#500000;
		err_total++;
		wrap_up();
	end
endmodule : tfc_function_ctrl_tb_top
